// >>> rtl/oricfg_consts.vh
// Constants for the orientation interrupt configuration block.
// Assumes a 25 MHz core clock and 8-bit register access at byte addresses.
`ifndef ORICFG_CONSTS_VH
`define ORICFG_CONSTS_VH
`define ORI_ADDR_LOW        8'h65
`define ORI_ADDR_HIGH       8'h66
`define ORI_RST_LOW         8'h18
`define ORI_RST_HIGH        8'h48
`define ORI_BLK_MSB         3
`define ORI_BLK_LSB         2
`define ORI_MODE_MSB        1
`define ORI_MODE_LSB        0
`define ORI_ROT_BIT         7
`define ORI_UD_BIT          6
`define ORI_THETA_MSB       5
`define ORI_THETA_LSB       0
`define ORI_BLK_NONE        2'h0
`define ORI_BLK_BIG         2'h1
`define ORI_BLK_SLOPE2      2'h2
`define ORI_BLK_SLOPE4      2'h3
`define ORI_MODE_SYM        2'h0
`define ORI_MODE_HIGH       2'h1
`define ORI_MODE_LOW        2'h2
// Magnitudes in milli-g, signed 16-bit axis data at 1 mg per LSB.
`define ORI_MAG_MG          16'h05DC
`define ORI_SLOPE2_MG       16'h00C8
`define ORI_SLOPE4_MG       16'h0190
// Stable time: 100 ms at 25 MHz is 2,500,000 cycles, sized to the stability counter.
`define ORI_STABLE_MS       100
`define ORI_CLK_KHZ         25000
`define ORI_STABLE_CYC      24'h2625A0
`endif

// >>> rtl/oricfg_axis_chk.v
// One axis checker: magnitude and slope against thresholds.
// Assumes samples arrive with a one-cycle valid strobe.
`timescale 1ns/1ps
`default_nettype none
module oricfg_axis_chk (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        valid_i,
  input  wire [15:0] sample_i,
  input  wire [15:0] slope_lim_i,
  input  wire [15:0] mag_lim_i,
  output reg         mag_over_o,
  output reg         slope_over_o
);
  reg  [15:0] prev;
  wire [15:0] mag   = sample_i[15] ? (~sample_i + 16'h0001) : sample_i;
  wire [16:0] diff  = {sample_i[15], sample_i} - {prev[15], prev};
  wire [16:0] adiff = diff[16] ? (~diff + 17'h00001) : diff;

  // Flags are refreshed per sample; slope compares consecutive samples.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev         <= 16'h0000;
      mag_over_o   <= 1'b0;
      slope_over_o <= 1'b0;
    end else if (valid_i) begin
      prev         <= sample_i;
      mag_over_o   <= mag > mag_lim_i;
      slope_over_o <= adiff > {1'b0, slope_lim_i};
    end
  end
endmodule
`default_nettype wire

// >>> rtl/oricfg_top.v
// Orientation interrupt configuration and event gating.
// Assumes a byte register port and signed 1 mg/LSB axis samples with a valid strobe.
// Assumes the orientation code and the tilt block condition are computed outside.
`timescale 1ns/1ps
`default_nettype none
`include "oricfg_consts.vh"
module oricfg_top (
  input  wire        CLOCK_I,
  input  wire        SYS_RST_I,
  input  wire [7:0]  REG_ADDR_I,
  input  wire        REG_WR_I,
  input  wire [7:0]  REG_WDATA_I,
  output reg  [7:0]  REG_RDATA_O,
  input  wire        SAMPLE_VALID_I,
  input  wire [15:0] SENSOR_X_I,
  input  wire [15:0] SENSOR_Y_I,
  input  wire [15:0] SENSOR_Z_I,
  input  wire [1:0]  ORIENT_XY_I,
  input  wire        ORIENT_UD_I,
  input  wire        TILT_OVER_I,
  output reg  [15:0] REG_X_O,
  output reg  [15:0] REG_Y_O,
  output reg  [15:0] REG_Z_O,
  output reg  [1:0]  THRESH_STYLE_O,
  output reg         ASYM_HIGH_O,
  output reg         ASYM_LOW_O,
  output reg  [5:0]  TILT_ANGLE_O,
  output reg         BLOCKED_O,
  output reg         ORIENT_IRQ_O
);
  reg  [7:0]  cfg_low;
  reg  [7:0]  cfg_high;
  reg  [7:0]  next_cfg_low;
  reg  [7:0]  next_cfg_high;
  reg  [7:0]  next_rdata;
  reg  [1:0]  xy_prev;
  reg         ud_prev;
  reg  [23:0] stable_cnt;
  wire [1:0]  blk_mode   = cfg_low[`ORI_BLK_MSB:`ORI_BLK_LSB];
  wire [1:0]  thr_mode   = cfg_low[`ORI_MODE_MSB:`ORI_MODE_LSB];
  wire        rotate     = cfg_high[`ORI_ROT_BIT];
  wire        ud_en      = cfg_high[`ORI_UD_BIT];
  wire [15:0] slope_lim  = (blk_mode == `ORI_BLK_SLOPE4) ? `ORI_SLOPE4_MG : `ORI_SLOPE2_MG;
  wire [2:0]  mag_over;
  wire [2:0]  slope_over;
  wire        stable     = (stable_cnt >= `ORI_STABLE_CYC);
  reg         block_now;
  wire        xy_change  = ORIENT_XY_I != xy_prev;
  wire        ud_toggle  = ORIENT_UD_I != ud_prev;
  wire        ud_change  = ud_toggle && ud_en;
  wire        next_irq   = (xy_change | ud_change) & ~block_now;
  wire [15:0] ax [0:2];

  // Axis samples gathered into an array so that the checkers can be generated.
  assign ax[0] = SENSOR_X_I;
  assign ax[1] = SENSOR_Y_I;
  assign ax[2] = SENSOR_Z_I;

  // One checker per sensor axis; the slope limit follows the selected mode, the magnitude limit is fixed.
  // Flags are refreshed only on a valid strobe, so they hold between samples.
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_axis
      oricfg_axis_chk u_oricfg_axis_chk (
        .clk_i        (CLOCK_I),
        .rst_i        (SYS_RST_I),
        .valid_i      (SAMPLE_VALID_I),
        .sample_i     (ax[g]),
        .slope_lim_i  (slope_lim),
        .mag_lim_i    (`ORI_MAG_MG),
        .mag_over_o   (mag_over[g]),
        .slope_over_o (slope_over[g])
      );
    end
  endgenerate

  // Write decode; a write to any other address changes nothing and is not flagged.
  // Every bit of both bytes is writable, hysteresis included, so software reads back
  // exactly what it wrote even where this block does not use the field.
  always @* begin
    next_cfg_low  = cfg_low;
    next_cfg_high = cfg_high;
    if (REG_WR_I && (REG_ADDR_I == `ORI_ADDR_LOW)) begin
      next_cfg_low = REG_WDATA_I;
    end
    if (REG_WR_I && (REG_ADDR_I == `ORI_ADDR_HIGH)) begin
      next_cfg_high = REG_WDATA_I;
    end
  end

  // Configuration bytes, loaded with their reset values.
  always @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      cfg_low  <= `ORI_RST_LOW;
      cfg_high <= `ORI_RST_HIGH;
    end else begin
      cfg_low  <= next_cfg_low;
      cfg_high <= next_cfg_high;
    end
  end

  // Blocking condition chosen by the mode field.
  // It uses the flags of the last sample, so a flag-driven block lasts until a sample clears it;
  // this errs on the side of suppressing an event rather than raising a false one.
  always @* begin
    case (blk_mode)
      `ORI_BLK_NONE: begin
        block_now = 1'b0;
      end
      `ORI_BLK_BIG: begin
        block_now = TILT_OVER_I | (|mag_over);
      end
      `ORI_BLK_SLOPE2: begin
        block_now = TILT_OVER_I | (|mag_over) | (|slope_over);
      end
      `ORI_BLK_SLOPE4: begin
        block_now = TILT_OVER_I | (|mag_over) | (|slope_over) | ~stable;
      end
      default: begin
        block_now = 1'b0;
      end
    endcase
  end

  // Stability timer restarts on any orientation change, up/down included even when its
  // interrupt is masked; it saturates so it never wraps back into an unstable reading.
  // Limitation: the window also runs from reset, so mode three blocks for 100 ms after it.
  always @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      stable_cnt <= 24'h000000;
    end else if (xy_change || ud_toggle) begin
      stable_cnt <= 24'h000000;
    end else if (!stable) begin
      stable_cnt <= stable_cnt + 24'h000001;
    end
  end

  // Orientation history; a change is measured against these previous values.
  // They reset to the idle level of the pins so that leaving reset is not a change.
  always @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      xy_prev <= 2'h0;
      ud_prev <= 1'b0;
    end else begin
      xy_prev <= ORIENT_XY_I;
      ud_prev <= ORIENT_UD_I;
    end
  end

  // Interrupt pulse and blocking level. A change that meets an active block is dropped,
  // not deferred, so a blocked change never turns up later as a stale interrupt.
  always @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ORIENT_IRQ_O <= 1'b0;
      BLOCKED_O    <= 1'b0;
    end else begin
      ORIENT_IRQ_O <= next_irq;
      BLOCKED_O    <= block_now;
    end
  end

  // Axis remap, registered so that all three axes move on the same edge.
  always @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      REG_X_O <= 16'h0000;
      REG_Y_O <= 16'h0000;
      REG_Z_O <= 16'h0000;
    end else begin
      REG_X_O <= rotate ? SENSOR_Y_I : SENSOR_X_I;
      REG_Y_O <= rotate ? SENSOR_Z_I : SENSOR_Y_I;
      REG_Z_O <= rotate ? SENSOR_X_I : SENSOR_Z_I;
    end
  end

  // Threshold style and tilt angle are only exported; the orientation computation
  // that applies them lives outside this block.
  always @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      THRESH_STYLE_O <= 2'h0;
      ASYM_HIGH_O    <= 1'b0;
      ASYM_LOW_O     <= 1'b0;
      TILT_ANGLE_O   <= 6'h00;
    end else begin
      THRESH_STYLE_O <= thr_mode;
      ASYM_HIGH_O    <= (thr_mode == `ORI_MODE_HIGH);
      ASYM_LOW_O     <= (thr_mode == `ORI_MODE_LOW);
      TILT_ANGLE_O   <= cfg_high[`ORI_THETA_MSB:`ORI_THETA_LSB];
    end
  end

  // Read data selection; unmapped addresses read as zero.
  always @* begin
    case (REG_ADDR_I)
      `ORI_ADDR_LOW: begin
        next_rdata = cfg_low;
      end
      `ORI_ADDR_HIGH: begin
        next_rdata = cfg_high;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // Read data is registered, so it trails the address by one cycle.
  always @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      REG_RDATA_O <= 8'h00;
    end else begin
      REG_RDATA_O <= next_rdata;
    end
  end
endmodule
`default_nettype wire

// >>> dv/oricfg_assertions.sv
// Port checker for the orientation interrupt configuration block.
// Assumes it is bound to oricfg_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module oricfg_checker (
  input wire logic        CLOCK_I,
  input wire logic        SYS_RST_I,
  input wire logic [7:0]  REG_ADDR_I,
  input wire logic        REG_WR_I,
  input wire logic [7:0]  REG_RDATA_O,
  input wire logic [15:0] SENSOR_X_I,
  input wire logic [15:0] SENSOR_Y_I,
  input wire logic [15:0] SENSOR_Z_I,
  input wire logic [1:0]  ORIENT_XY_I,
  input wire logic        ORIENT_UD_I,
  input wire logic [15:0] REG_X_O,
  input wire logic [15:0] REG_Y_O,
  input wire logic [15:0] REG_Z_O,
  input wire logic [1:0]  THRESH_STYLE_O,
  input wire logic        ASYM_HIGH_O,
  input wire logic        ASYM_LOW_O,
  input wire logic [5:0]  TILT_ANGLE_O,
  input wire logic        BLOCKED_O,
  input wire logic        ORIENT_IRQ_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);
  // Remapping moves all three axes together, never one alone.
  property p_rot;
    REG_X_O != $past(SENSOR_X_I) |-> REG_X_O == $past(SENSOR_Y_I) &&
      REG_Y_O == $past(SENSOR_Z_I) && REG_Z_O == $past(SENSOR_X_I);
  endproperty
  a_rot: assert property (p_rot) else $error("axis remap inconsistent");
  property p_asym_high;
    ASYM_HIGH_O == (THRESH_STYLE_O == 2'h1);
  endproperty
  a_asym_high: assert property (p_asym_high) else $error("high asym flag wrong");
  property p_asym_low;
    ASYM_LOW_O == (THRESH_STYLE_O == 2'h2);
  endproperty
  a_asym_low: assert property (p_asym_low) else $error("low asym flag wrong");
  // A pulse is allowed only one edge after an orientation change.
  property p_irq_cause;
    ORIENT_IRQ_O |-> $past(ORIENT_XY_I) != $past(ORIENT_XY_I, 2) ||
      $past(ORIENT_UD_I) != $past(ORIENT_UD_I, 2);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without change");
  // A dropped change shows as blocking on the same edge as the missing pulse.
  property p_irq_blocked;
    ORIENT_IRQ_O |-> !BLOCKED_O;
  endproperty
  a_irq_blocked: assert property (p_irq_blocked) else $error("interrupt while blocked");
  property p_style_hold;
    !$past(REG_WR_I) && !$past(REG_WR_I, 2) |-> $stable(THRESH_STYLE_O);
  endproperty
  a_style_hold: assert property (p_style_hold) else $error("style moved without write");
  property p_rd_low;
    $past(REG_ADDR_I) == 8'h65 && !$past(REG_WR_I) |-> REG_RDATA_O[1:0] == THRESH_STYLE_O;
  endproperty
  a_rd_low: assert property (p_rd_low) else $error("style field readback differs");
  property p_rd_high;
    $past(REG_ADDR_I) == 8'h66 && !$past(REG_WR_I) |-> REG_RDATA_O[5:0] == TILT_ANGLE_O;
  endproperty
  a_rd_high: assert property (p_rd_high) else $error("angle field readback differs");
  property p_unmapped;
    $past(REG_ADDR_I) != 8'h65 && $past(REG_ADDR_I) != 8'h66 |-> REG_RDATA_O == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
bind oricfg_top oricfg_checker u_oricfg_checker (
  .CLOCK_I        (CLOCK_I),
  .SYS_RST_I      (SYS_RST_I),
  .REG_ADDR_I     (REG_ADDR_I),
  .REG_WR_I       (REG_WR_I),
  .REG_RDATA_O    (REG_RDATA_O),
  .SENSOR_X_I     (SENSOR_X_I),
  .SENSOR_Y_I     (SENSOR_Y_I),
  .SENSOR_Z_I     (SENSOR_Z_I),
  .ORIENT_XY_I    (ORIENT_XY_I),
  .ORIENT_UD_I    (ORIENT_UD_I),
  .REG_X_O        (REG_X_O),
  .REG_Y_O        (REG_Y_O),
  .REG_Z_O        (REG_Z_O),
  .THRESH_STYLE_O (THRESH_STYLE_O),
  .ASYM_HIGH_O    (ASYM_HIGH_O),
  .ASYM_LOW_O     (ASYM_LOW_O),
  .TILT_ANGLE_O   (TILT_ANGLE_O),
  .BLOCKED_O      (BLOCKED_O),
  .ORIENT_IRQ_O   (ORIENT_IRQ_O)
);
`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench for the orientation interrupt configuration block.
// Assumes oricfg_top is driven directly; inputs change 1 ns after each rising edge.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 0, rst = 1, wr = 0, vld = 0, ud = 0, tilt = 0, ah, al, blk, irq;
  logic [7:0]  addr = 8'h00, wd = 8'h00, rd;
  logic [15:0] sx = 16'h0000, sy = 16'h0000, sz = 16'h0000, rx, ry, rz;
  logic [1:0]  xy = 2'h0, sty;
  logic [5:0]  ang;
  int          miscompares = 0, samples_checked = 0;
  // Free-running 25 MHz clock.
  always #20 clk = ~clk;
  oricfg_top u_oricfg_top (.CLOCK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr), .REG_WR_I(wr),
    .REG_WDATA_I(wd), .REG_RDATA_O(rd), .SAMPLE_VALID_I(vld), .SENSOR_X_I(sx), .SENSOR_Y_I(sy),
    .SENSOR_Z_I(sz), .ORIENT_XY_I(xy), .ORIENT_UD_I(ud), .TILT_OVER_I(tilt), .REG_X_O(rx),
    .REG_Y_O(ry), .REG_Z_O(rz), .THRESH_STYLE_O(sty), .ASYM_HIGH_O(ah), .ASYM_LOW_O(al),
    .TILT_ANGLE_O(ang), .BLOCKED_O(blk), .ORIENT_IRQ_O(irq));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Every task starts and ends 1 ns after a rising edge.
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wd = d;
    wr = 1'b1;
    step(1);
    wr = 1'b0;
    step(1);
  endtask
  // Presents one x sample and waits until the blocking level reflects it.
  task automatic sample_x(input logic [15:0] x);
    sx = x;
    vld = 1'b1;
    step(1);
    vld = 1'b0;
    step(2);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    addr = a;
    step(2);
    chk({8'h00, rd}, {8'h00, e});
  endtask
  // Counts pulses in a four-cycle window after the new orientation is applied.
  task automatic irq_after(input logic [1:0] nxy, input logic nud, input logic [15:0] e);
    logic [15:0] n;
    n = 16'h0000;
    xy = nxy;
    ud = nud;
    repeat (4) begin
      step(1);
      n = n + irq;
    end
    chk(n, e);
  endtask
  task automatic t_regs;
    rd_chk(8'h65, 8'h18);
    rd_chk(8'h66, 8'h48);
    rd_chk(8'h70, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr_reg(8'h65, m[7:0]);
      step(2);
      chk({14'h0000, sty}, m[15:0]);
      chk({14'h0000, ah, al}, {14'h0000, m == 1, m == 2});
    end
    $display("test registers done");
  endtask
  task automatic t_remap;
    wr_reg(8'h66, 8'hFF);
    sx = 16'h0111;
    sy = 16'h0222;
    sz = 16'h0333;
    vld = 1'b1;
    step(1);
    vld = 1'b0;
    step(1);
    chk({10'h000, ang}, 16'h003F);
    chk(rx, sy);
    chk(ry, sz);
    chk(rz, sx);
    wr_reg(8'h66, 8'h7F);
    step(2);
    chk(rx, sx);
    chk(ry, sy);
    chk(rz, sz);
    $display("test remap done");
  endtask
  task automatic t_irq;
    irq_after(2'h1, 1'b0, 16'h0001);
    wr_reg(8'h66, 8'h3F);
    irq_after(2'h1, 1'b1, 16'h0000);
    wr_reg(8'h66, 8'h7F);
    irq_after(2'h1, 1'b0, 16'h0001);
    tilt = 1'b1;
    irq_after(2'h2, 1'b0, 16'h0001);
    wr_reg(8'h65, 8'h04);
    step(2);
    irq_after(2'h3, 1'b0, 16'h0000);
    chk({15'h0000, blk}, 16'h0001);
    tilt = 1'b0;
    wr_reg(8'h65, 8'h08);
    sx = 16'h0400;
    vld = 1'b1;
    step(1);
    vld = 1'b0;
    step(2);
    chk({15'h0000, blk}, 16'h0001);
    irq_after(2'h0, 1'b0, 16'h0000);
    $display("test interrupt done");
  endtask
  // Slope and magnitude limits at their boundaries, then blocking by stability alone.
  task automatic t_block;
    sample_x(16'h0400);
    chk({15'h0000, blk}, 16'h0000);
    sample_x(16'h04C8);
    chk({15'h0000, blk}, 16'h0000);
    sample_x(16'h0591);
    chk({15'h0000, blk}, 16'h0001);
    wr_reg(8'h65, 8'h04);
    sample_x(16'h05DC);
    chk({15'h0000, blk}, 16'h0000);
    sample_x(16'h05DD);
    chk({15'h0000, blk}, 16'h0001);
    sample_x(16'hFA23);
    chk({15'h0000, blk}, 16'h0001);
    sample_x(16'h0100);
    sample_x(16'h0100);
    chk({15'h0000, blk}, 16'h0000);
    wr_reg(8'h65, 8'h0C);
    step(1);
    chk({15'h0000, blk}, 16'h0001);
    irq_after(2'h1, 1'b0, 16'h0000);
    wr_reg(8'h65, 8'h08);
    step(1);
    chk({15'h0000, blk}, 16'h0000);
    irq_after(2'h2, 1'b0, 16'h0001);
    $display("test blocking done");
  endtask
  // A reset in mid-run brings both configuration bytes back to their reset values.
  task automatic t_reset;
    wr_reg(8'h66, 8'h80);
    sx = 16'h0000;
    sy = 16'h0000;
    sz = 16'h0000;
    xy = 2'h0;
    step(2);
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    rd_chk(8'h65, 8'h18);
    rd_chk(8'h66, 8'h48);
    chk({10'h000, ang}, 16'h0008);
    chk({15'h0000, blk}, 16'h0000);
    $display("test reset done");
  endtask
  task automatic tally_and_finish;
    $display("checked=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Main sequence after a 20-cycle reset.
  initial begin
    step(20);
    rst = 1'b0;
    t_regs;
    t_remap;
    t_irq;
    t_block;
    t_reset;
    tally_and_finish;
  end
  // Watchdog well beyond the roughly 140 cycles the tests need.
  initial begin
    #200000;
    miscompares++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
